// ==== verilog/mspi_master.sv ====
// Purpose: Serial transceiver operating as a three-wire SPI master.
// Assumes: Control inputs synchronous to i_ref_clk; software follows setup order.
// Notes:   No slave select and no slave mode; the serial clock is always generated.
`timescale 1ns/100ps
// Summary of operation
// - Master SPI logic runs only when the mode select field equals binary 11.
// - Parity, clock recovery and asynchronous framing are absent in this mode.
// - Serial clock is always generated internally; no external clock input exists.
// - Bit rate is system clock over two times (divisor plus one).
// - Fastest serial clock is half the system clock, with divisor zero.
// - Mode is polarity*2+phase; phase picks sample edge, polarity picks idle level.
// - Data shifts out on one clock edge and is latched on the other.
// - Every frame carries exactly eight bits, MSB or LSB first.
// - Receiver and transmitter share the single bit order setting.
// - After a frame the next starts at once or data line idles high.
// - Two queued bytes go out back to back; completion flags after both.
// - Transmitter may run alone; receiver needs the transmitter enabled.
// - Reset clears the baud divisor to zero.
// - Transmit path is double buffered so a byte can queue during shifting.
// - Same register set, pin control and interrupts as normal serial mode.
// - A write to the data buffer starts a transfer, for send or receive.
// - On receive overflow the newest byte is dropped, older unread bytes kept.
// - Frame error, overrun and parity error flags always read zero.
// - Transmit complete sets when shifter empties with nothing buffered; write-one clears.
module mspi_master
  import mspi_pkg::*;
#(
  parameter int unsigned FRAME_BITS = DATA_W
) (
  // Clock and reset
  input  wire logic              i_ref_clk,
  input  wire logic              i_rst,
  // Configuration
  input  wire logic [1:0]        i_op_mode_select,
  input  wire logic              i_clock_polarity,
  input  wire logic              i_clock_phase,
  input  wire logic              i_bit_order_select,
  input  wire logic              i_transmitter_enable,
  input  wire logic              i_receiver_enable,
  input  wire logic              i_sclk_pin_direction,
  // Baud divisor write port
  input  wire logic              i_baud_divisor_wr,
  input  wire logic [BAUD_W-1:0] i_baud_divisor,
  output logic [BAUD_W-1:0]      o_baud_divisor,
  // Data buffer access
  input  wire logic              i_data_buffer_wr,
  input  wire logic [7:0]        i_data_buffer_wdata,
  input  wire logic              i_data_buffer_rd,
  output logic [7:0]             o_data_buffer_rdata,
  // Status
  output logic                   o_buffer_empty_flag,
  output logic                   o_receive_complete_flag,
  output logic                   o_transmit_complete_flag,
  input  wire logic              i_transmit_complete_clr,
  output logic                   o_frame_error_flag,
  output logic                   o_data_overrun_flag,
  output logic                   o_parity_error_flag,
  output logic                   o_spi_master_mode,
  // Serial pins
  output logic                   o_serial_clock_pin,
  output logic                   o_serial_clock_oe,
  output logic                   o_serial_out_pin,
  output logic                   o_serial_out_oe,
  input  wire logic              i_serial_in_pin
);
  typedef enum logic [1:0] {ST_IDLE, ST_LEAD, ST_TRAIL} state_t;

  state_t            state_q, state_d;
  logic [BAUD_W-1:0] baud_q, baud_d;
  logic [BAUD_W-1:0] tick_cnt_q, tick_cnt_d;
  logic [7:0]        tx_buf_q, tx_buf_d;
  logic              tx_full_q, tx_full_d;
  logic [7:0]        tx_sh_q, tx_sh_d;
  logic [7:0]        rx_sh_q, rx_sh_d;
  logic [3:0]        bit_q, bit_d;
  logic              sclk_q, sclk_d;
  logic              sdo_q, sdo_d;
  logic              txc_q, txc_d;
  logic              rx_push_q, rx_push_d;
  logic [7:0]        rx_word_q, rx_word_d;
  logic              mst_en, tx_on, rx_on, tick;
  logic              rx_out_valid;
  logic [7:0]        rx_out_data;
  logic              sample_lead;
  logic              in_bit;

  assign mst_en      = (i_op_mode_select == MODE_SPI_MST);
  assign tx_on       = mst_en && i_transmitter_enable;
  assign rx_on       = tx_on && i_receiver_enable;
  assign tick        = (tick_cnt_q == '0);
  assign sample_lead = ~i_clock_phase;

  // Bit order is one setting for both directions
  function automatic logic [7:0] pick_order(input logic [7:0] v, input logic msb_first);
    logic [7:0] r;
    r = v;
    if (!msb_first) begin
      for (int i = 0; i < 8; i++) begin
        r[i] = v[7-i];
      end
    end
    return r;
  endfunction

  // Buffer and transfer state
  always_comb begin
    state_d    = state_q;
    baud_d     = baud_q;
    tick_cnt_d = tick_cnt_q;
    tx_buf_d   = tx_buf_q;
    tx_full_d  = tx_full_q;
    tx_sh_d    = tx_sh_q;
    rx_sh_d    = rx_sh_q;
    bit_d      = bit_q;
    sclk_d     = sclk_q;
    sdo_d      = sdo_q;
    txc_d      = txc_q;
    rx_push_d  = 1'b0;
    rx_word_d  = rx_word_q;
    in_bit     = i_serial_in_pin;

    if (i_baud_divisor_wr) begin
      baud_d = i_baud_divisor;
    end
    if (i_transmit_complete_clr) begin
      txc_d = 1'b0;
    end
    if (i_data_buffer_wr && tx_on && !tx_full_q) begin
      tx_buf_d  = i_data_buffer_wdata;
      tx_full_d = 1'b1;
    end

    // Half-period timer: each tick is one serial clock edge
    if (state_q == ST_IDLE || tick) begin
      tick_cnt_d = baud_q;
    end else begin
      tick_cnt_d = tick_cnt_q - 1'b1;
    end

    case (state_q)
      ST_IDLE: begin
        sclk_d = i_clock_polarity;
        sdo_d  = 1'b1;
        if (tx_full_q && tx_on) begin
          tx_sh_d   = pick_order(tx_buf_q, i_bit_order_select);
          tx_full_d = 1'b0;
          bit_d     = 4'h0;
          if (sample_lead) begin
            sdo_d = tx_sh_d[7];
          end
          state_d = ST_LEAD;
        end
      end
      ST_LEAD: begin
        if (tick) begin
          sclk_d = ~i_clock_polarity;
          if (sample_lead) begin
            rx_sh_d = {rx_sh_q[6:0], in_bit};
          end else begin
            sdo_d = tx_sh_q[7];
          end
          state_d = ST_TRAIL;
        end
      end
      ST_TRAIL: begin
        if (tick) begin
          sclk_d  = i_clock_polarity;
          tx_sh_d = {tx_sh_q[6:0], 1'b0};
          if (!sample_lead) begin
            rx_sh_d = {rx_sh_q[6:0], in_bit};
          end
          if (bit_q == BIT_LAST) begin
            rx_word_d = pick_order(sample_lead ? rx_sh_q : {rx_sh_q[6:0], in_bit},
                                   i_bit_order_select);
            rx_push_d = rx_on;
            if (tx_full_q && tx_on) begin
              tx_sh_d   = pick_order(tx_buf_q, i_bit_order_select);
              tx_full_d = 1'b0;
              bit_d     = 4'h0;
              sdo_d     = sample_lead ? tx_sh_d[7] : sdo_q;
              state_d   = ST_LEAD;
            end else begin
              txc_d   = 1'b1;
              // Phase one samples on this edge, so the last bit holds one more clock
              sdo_d   = sample_lead ? 1'b1 : sdo_q;
              state_d = ST_IDLE;
            end
          end else begin
            bit_d = bit_q + 4'h1;
            if (sample_lead) begin
              sdo_d = tx_sh_d[7];
            end
            state_d = ST_LEAD;
          end
        end
      end
      default: state_d = ST_IDLE;
    endcase

    // Dropping the transmitter abandons the frame and the queued byte
    if (!tx_on) begin
      state_d   = ST_IDLE;
      tx_full_d = 1'b0;
      sclk_d    = i_clock_polarity;
      sdo_d     = 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      state_q    <= ST_IDLE;
      baud_q     <= BAUD_RST;
      tick_cnt_q <= BAUD_RST;
      tx_buf_q   <= 8'h00;
      tx_full_q  <= 1'b0;
      tx_sh_q    <= 8'h00;
      rx_sh_q    <= 8'h00;
      bit_q      <= 4'h0;
      sclk_q     <= 1'b0;
      sdo_q      <= 1'b1;
      txc_q      <= 1'b0;
      rx_push_q  <= 1'b0;
      rx_word_q  <= 8'h00;
    end else begin
      state_q    <= state_d;
      baud_q     <= baud_d;
      tick_cnt_q <= tick_cnt_d;
      tx_buf_q   <= tx_buf_d;
      tx_full_q  <= tx_full_d;
      tx_sh_q    <= tx_sh_d;
      rx_sh_q    <= rx_sh_d;
      bit_q      <= bit_d;
      sclk_q     <= sclk_d;
      sdo_q      <= sdo_d;
      txc_q      <= txc_d;
      rx_push_q  <= rx_push_d;
      rx_word_q  <= rx_word_d;
    end
  end

  // Receive buffer; a full buffer refuses the new byte so the old ones survive
  mspi_buf2 #(
    .WIDTH (8)
  ) u_rx_buf (
    .i_ref_clk   (i_ref_clk),
    .i_rst       (i_rst),
    .i_flush     (~rx_on),
    .i_in_valid  (rx_push_q),
    .o_in_ready  (),
    .i_in_data   (rx_word_q),
    .o_out_valid (rx_out_valid),
    .i_out_ready (i_data_buffer_rd),
    .o_out_data  (rx_out_data)
  );

  assign o_data_buffer_rdata      = rx_out_data;
  assign o_receive_complete_flag  = rx_out_valid;
  assign o_buffer_empty_flag      = ~tx_full_q;
  assign o_transmit_complete_flag = txc_q;
  assign o_baud_divisor           = baud_q;
  assign o_frame_error_flag       = 1'b0;
  assign o_data_overrun_flag      = 1'b0;
  assign o_parity_error_flag      = 1'b0;
  assign o_spi_master_mode        = mst_en;
  // Idle pin follows polarity at once, so reset or a mode change gives no stray edge
  assign o_serial_clock_pin       = (tx_on && state_q != ST_IDLE) ? sclk_q
                                                                  : i_clock_polarity;
  assign o_serial_clock_oe        = i_sclk_pin_direction;
  assign o_serial_out_pin         = sdo_q;
  assign o_serial_out_oe          = tx_on;
endmodule

// ==== verilog/mspi_pkg.sv ====
// Purpose: Shared constants for the serial-transceiver SPI master block.
// Assumes: One system clock of 250 MHz; all control bits arrive as plain ports.
// Notes:   The SPI master mode select encoding lives here with the frame size.
package mspi_pkg;
  localparam int unsigned DATA_W       = 8;
  localparam int unsigned BAUD_W       = 12;
  localparam logic [1:0]  MODE_SPI_MST = 2'h3;
  localparam logic [BAUD_W-1:0] BAUD_RST = 12'h000;
  localparam logic [3:0]  BIT_LAST     = 4'h7;
  localparam int unsigned RXBUF_DEPTH  = 2;
endpackage

// ==== verilog/mspi_buf2.sv ====
// Purpose: Two-entry valid/ready buffer on the receive data path.
// Assumes: Synchronous active-high reset.
// Notes:   When full, in_ready drops and the arriving word is the one lost.
`timescale 1ns/100ps
module mspi_buf2 #(
  parameter int unsigned WIDTH = 8
) (
  // Clock and reset
  input  wire logic             i_ref_clk,
  input  wire logic             i_rst,
  input  wire logic             i_flush,
  // Fill side
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  // Drain side
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic [WIDTH-1:0]      o_out_data
);
  logic [WIDTH-1:0] mem_q [2];
  logic [WIDTH-1:0] mem_d [2];
  logic             rd_q, rd_d, wr_q, wr_d;
  logic [1:0]       cnt_q, cnt_d;
  logic             push, pop;

  assign o_in_ready  = (cnt_q != 2'h2);
  assign o_out_valid = (cnt_q != 2'h0);
  assign o_out_data  = mem_q[rd_q];
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;

  always_comb begin
    mem_d = mem_q;
    rd_d  = rd_q;
    wr_d  = wr_q;
    cnt_d = cnt_q;
    if (push) begin
      mem_d[wr_q] = i_in_data;
      wr_d        = ~wr_q;
    end
    if (pop) begin
      rd_d = ~rd_q;
    end
    cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
    if (i_flush) begin
      rd_d  = 1'b0;
      wr_d  = 1'b0;
      cnt_d = 2'h0;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      mem_q[0] <= '0;
      mem_q[1] <= '0;
      rd_q     <= 1'b0;
      wr_q     <= 1'b0;
      cnt_q    <= 2'h0;
    end else begin
      mem_q <= mem_d;
      rd_q  <= rd_d;
      wr_q  <= wr_d;
      cnt_q <= cnt_d;
    end
  end
endmodule

// ==== tb/mspi_master_asserts.sv ====
// Purpose: Port-level checks for the SPI master.
// Assumes: One clock, sync active-high reset.
// Notes:   Bound into every mspi_master instance.
`timescale 1ns/100ps
module mspi_master_asserts
  import mspi_pkg::*;
(
  // Clock, reset and controls
  input wire logic              i_ref_clk,
  input wire logic              i_rst,
  input wire logic [1:0]        i_op_mode_select,
  input wire logic              i_clock_polarity,
  input wire logic              i_transmitter_enable,
  input wire logic              i_sclk_pin_direction,
  input wire logic              i_data_buffer_wr,
  input wire logic              i_transmit_complete_clr,
  // Watched outputs
  input wire logic [BAUD_W-1:0] o_baud_divisor,
  input wire logic              o_buffer_empty_flag,
  input wire logic              o_transmit_complete_flag,
  input wire logic              o_frame_error_flag,
  input wire logic              o_data_overrun_flag,
  input wire logic              o_parity_error_flag,
  input wire logic              o_spi_master_mode,
  input wire logic              o_serial_clock_pin,
  input wire logic              o_serial_clock_oe,
  input wire logic              o_serial_out_pin
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  // Cycles since the last serial clock edge, saturating
  logic [12:0] gap_q, gap_d;
  logic        sck_q;
  always_comb begin
    gap_d = (o_serial_clock_pin != sck_q) ? 13'h0001 : gap_q + 13'(gap_q != 13'h1fff);
  end
  always_ff @(posedge i_ref_clk) begin
    sck_q <= o_serial_clock_pin;
    gap_q <= i_rst ? 13'h0000 : gap_d;
  end
  sequence wr_taken_s;
    i_data_buffer_wr && o_buffer_empty_flag && i_transmitter_enable && o_spi_master_mode;
  endsequence
  sequence frame_done_s;
    $rose(o_transmit_complete_flag);
  endsequence
  err_flags_zero_a: assert property (
    !(o_frame_error_flag || o_data_overrun_flag || o_parity_error_flag))
    else $error("error flag set");
  mode_decode_a: assert property (o_spi_master_mode == (i_op_mode_select == MODE_SPI_MST))
    else $error("mode decode wrong");
  sck_output_a: assert property (o_serial_clock_oe == i_sclk_pin_direction)
    else $error("clock pin not driven");
  baud_reset_a: assert property ($fell(i_rst) |-> o_baud_divisor == BAUD_RST)
    else $error("divisor not cleared");
  buf_take_a: assert property (wr_taken_s |=> !o_buffer_empty_flag)
    else $error("write not taken");
  txc_hold_a: assert property (
    o_transmit_complete_flag && !i_transmit_complete_clr |=> o_transmit_complete_flag)
    else $error("txc lost");
  txc_clear_a: assert property (
    o_transmit_complete_flag && i_transmit_complete_clr |=> !o_transmit_complete_flag)
    else $error("txc not cleared");
  sck_rate_a: assert property (
    $changed(o_serial_clock_pin) |-> gap_q > {1'b0, o_baud_divisor})
    else $error("clock half period short");
  sck_idle_a: assert property (frame_done_s |-> o_serial_clock_pin == i_clock_polarity)
    else $error("clock not idle");
  mosi_idle_a: assert property (frame_done_s |-> ##[0:4] o_serial_out_pin)
    else $error("data line not idle high");
endmodule
bind mspi_master mspi_master_asserts chk_i (.*);

// ==== tb/mspi_slave_model.sv ====
// Purpose: Behavioural SPI slave on the master's serial pins.
// Assumes: Mode and bit order mirror the master's settings.
// Notes:   Reply byte n is 5a+n; i_sync realigns after a mode change.
`timescale 1ns/100ps
module mspi_slave_model (
  // Pins and settings
  input  wire logic i_sclk,
  input  wire logic i_mosi,
  input  wire logic i_cpol,
  input  wire logic i_cpha,
  input  wire logic i_msb_first,
  input  wire logic i_sync,
  output logic      o_miso
);
  logic [7:0] sh = 8'h00;
  logic [7:0] got[$];
  int k = 0;
  int nf = 0;
  function automatic logic bit_of(int n, int i);
    logic [7:0] b;
    b = 8'h5a + 8'(n);
    return i_msb_first ? b[7-i] : b[i];
  endfunction
  initial o_miso = 1'b0;
  always @(posedge i_sync) begin
    k = 0;
    o_miso = bit_of(nf, 0);
  end
  // Sample edge is rising when polarity equals phase; the other edge sets up
  always @(i_sclk) begin
    if (i_sclk === (i_cpol ~^ i_cpha)) begin
      sh = i_msb_first ? {sh[6:0], i_mosi} : {i_mosi, sh[7:1]};
      k++;
      if (k == 8) begin
        got.push_back(sh);
        k = 0;
        nf++;
      end
    end else begin
      o_miso = bit_of(nf, k);
    end
  end
endmodule

// ==== tb/mspi_master_tb.sv ====
// Purpose: Self-checking bench for the SPI master.
// Assumes: Inputs change 1 ns after the rising edge.
// Notes:   Small divisors keep the run short.
`timescale 1ns/100ps
module mspi_master_tb;
  import mspi_pkg::*;
  logic i_ref_clk = 0, i_rst = 1, i_clock_polarity, i_clock_phase, i_bit_order_select;
  logic i_transmitter_enable, i_receiver_enable, i_sclk_pin_direction, i_baud_divisor_wr;
  logic i_data_buffer_wr, i_data_buffer_rd, i_transmit_complete_clr, i_serial_in_pin, sync;
  logic [1:0] i_op_mode_select;
  logic [BAUD_W-1:0] i_baud_divisor, o_baud_divisor;
  logic [7:0] i_data_buffer_wdata, o_data_buffer_rdata;
  logic o_buffer_empty_flag, o_receive_complete_flag, o_transmit_complete_flag;
  logic o_frame_error_flag, o_data_overrun_flag, o_parity_error_flag, o_spi_master_mode;
  logic o_serial_clock_pin, o_serial_clock_oe, o_serial_out_pin, o_serial_out_oe;
  int error_cnt = 0, check_count = 0, nfr = 0, n0;
  time t0;
  mspi_master dut (.*);
  mspi_slave_model slv (.i_sclk(o_serial_clock_pin), .i_mosi(o_serial_out_pin),
    .i_cpol(i_clock_polarity), .i_cpha(i_clock_phase), .i_msb_first(i_bit_order_select),
    .i_sync(sync), .o_miso(i_serial_in_pin));
  initial begin
    forever #2 i_ref_clk = ~i_ref_clk;
  end
  task automatic stop_test;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(string nm, logic [11:0] seen, logic [11:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask
  task automatic put(logic [7:0] b);
    int t = 0;
    while (o_buffer_empty_flag !== 1'b1 && t < 3000) begin cyc(1); t++; end
    i_data_buffer_wr = 1;
    i_data_buffer_wdata = b;
    cyc(1);
    i_data_buffer_wr = 0;
  endtask
  task automatic wait_txc;
    int t = 0;
    while (o_transmit_complete_flag !== 1'b1 && t < 3000) begin cyc(1); t++; end
    chk("txc", o_transmit_complete_flag, 1);
    cyc(3);
    chk("mosi_idle", o_serial_out_pin, 1);
  endtask
  task automatic rd(logic [7:0] e);
    chk("rx", o_data_buffer_rdata, e);
    i_data_buffer_rd = 1;
    cyc(1);
    i_data_buffer_rd = 0;
    cyc(1);
  endtask
  task automatic clr;
    i_transmit_complete_clr = 1;
    cyc(1);
    i_transmit_complete_clr = 0;
  endtask
  task automatic setup(int m, logic o, logic [11:0] d);
    {i_clock_polarity, i_clock_phase} = 2'(m);
    i_bit_order_select = o;
    i_baud_divisor = d;
    i_baud_divisor_wr = 1;
    cyc(1);
    i_baud_divisor_wr = 0;
    cyc(4);
    sync = 1;
    cyc(1);
    sync = 0;
    chk("sck_idle", o_serial_clock_pin, i_clock_polarity);
  endtask
  initial begin
    {i_clock_polarity, i_clock_phase, i_bit_order_select, i_baud_divisor_wr, sync} = 0;
    {i_data_buffer_wr, i_data_buffer_rd, i_transmit_complete_clr} = 0;
    {i_transmitter_enable, i_receiver_enable, i_sclk_pin_direction} = 3'h7;
    i_op_mode_select = MODE_SPI_MST;
    i_baud_divisor = 12'h000;
    i_data_buffer_wdata = 8'h00;
    repeat (5) @(posedge i_ref_clk);
    #1 i_rst = 0;
    chk("baud", o_baud_divisor, 12'h000);
    chk("empty", o_buffer_empty_flag, 1);
    chk("errs", {o_frame_error_flag, o_data_overrun_flag, o_parity_error_flag}, 0);
    chk("mode", o_spi_master_mode, 1);
    chk("mosi_oe", o_serial_out_oe, 1);
    for (int m = 0; m < 8; m++) begin
      setup(m % 4, m / 4, 12'(m % 3));
      put(8'h3c ^ 8'(m * 37));
      wait_txc;
      chk("mosi", slv.got[$], 8'h3c ^ 8'(m * 37));
      rd(8'h5a + 8'(nfr));
      nfr++;
      clr;
    end
    setup(0, 1, 12'h003);
    chk("baud_rd", o_baud_divisor, 12'h003);
    n0 = slv.got.size();
    put(8'ha1);
    put(8'h7e);
    @(posedge o_serial_clock_pin) t0 = $time;
    @(posedge o_serial_clock_pin) chk("period", 12'(($time - t0) / 4), 12'h008);
    wait_txc;
    chk("pair", 12'(slv.got.size() - n0), 12'h002);
    rd(8'h5a + 8'(nfr));
    rd(8'h5a + 8'(nfr + 1));
    nfr += 2;
    clr;
    put(8'h11);
    put(8'h22);
    put(8'h33);
    wait_txc;
    rd(8'h5a + 8'(nfr));
    rd(8'h5a + 8'(nfr + 1));
    chk("rxc", o_receive_complete_flag, 0);
    nfr += 3;
    clr;
    i_receiver_enable = 0;
    put(8'h44);
    wait_txc;
    chk("rx_off", o_receive_complete_flag, 0);
    clr;
    i_op_mode_select = 2'h1;
    cyc(2);
    chk("mode_off", o_spi_master_mode, 0);
    chk("oe_off", o_serial_out_oe, 0);
    n0 = slv.got.size();
    i_data_buffer_wr = 1;
    cyc(1);
    i_data_buffer_wr = 0;
    cyc(60);
    chk("no_frame", 12'(slv.got.size() - n0), 12'h000);
    stop_test;
  end
  initial begin
    #100000;
    error_cnt++;
    stop_test;
  end
endmodule
